// File: aoc_pkg.sv
package aoc_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [7:0] FREE_CFG_OFS = 8'h00;
    localparam logic [7:0] FREE_CNT_OFS = 8'h04;
    localparam logic [7:0] PT_CTRL_OFS = 8'h08;
    localparam logic [7:0] PT_CFG_OFS = 8'h0C;
    localparam logic [7:0] PT_CNT_OFS = 8'h10;
    localparam logic [7:0] INT_STAT_OFS = 8'h14;
    localparam logic [7:0] INT_MASK_OFS = 8'h18;
    localparam logic [7:0] LP_CLK_CTL_OFS = 8'h1C;
    localparam int FREE_EN_BIT = 0;
    localparam int CLR_BIT = 0;
    localparam int RELOAD_BIT = 1;
    localparam int GATE_EN_BIT = 0;
    localparam int ALARM_BIT = 0;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic GATE_EN_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: aoc_tick_sync.sv
`timescale 1ns/1ps
`default_nettype none
module aoc_tick_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow_clk,
    output logic tick
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // The slow clock is sampled as a level; the tick compares the second and third stages.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= slow_clk;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign tick = sync_reg & ~prev_reg;
endmodule
`default_nettype wire

// File: aoc_counters.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1 - Free counter counts up each slow cycle.
// RL2 - Free counter advances only while enabled.
// RL3 - Periodic timer decrements from configured value.
// RL4 - Expiry at zero reloads and continues.
// RL5 - Timer disabled while configured value is zero.
// RL6 - Expiry sets alarm held until cleared.
// RL7 - Hardware clears reload and clear bits.
// RL8 - Reload bit loads configured value.
// RL9 - Alarm clear bit deasserts alarm.
// RL10 - Readable count lags one slow cycle.
// RL11 - Software checks free counter before reload.
// RL12 - Software start: configure, reload, poll.
// RL13 - Software service: stop, clear, poll.
// RL14 - Requests complete over slow clock cycles.
// RL15 - Gate bit zero stops both counters.
// RL16 - Requests cross via synchronised handshake.
// RL17 - Counters 32 bits, free counter wraps.
module aoc_counters #(
    parameter int CNT_W = 32
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic RTC_CLK,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic ALARM,
    output logic IRQ
);
    logic raw_tick;
    logic tick;
    logic [7:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic free_counter_enable_reg;
    logic [CNT_W-1:0] free_cnt_reg;
    logic alarm_clear_bit_reg;
    logic periodic_reload_bit_reg;
    logic [CNT_W-1:0] periodic_timeout_value_reg;
    logic [CNT_W-1:0] pt_live_reg;
    logic [CNT_W-1:0] periodic_count_value_reg;
    logic alarm_reg;
    logic int_stat_reg;
    logic int_mask_reg;
    logic counter_clock_gate_enable_reg;
    logic irq_reg;
    logic do_write;
    logic do_read;
    logic expire;
    logic stat_read;
    logic [31:0] wr_ofs_data;

    aoc_tick_sync u_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .slow_clk(RTC_CLK),
        .tick(raw_tick)
    );

    // Gating the tick rather than the clock keeps one clock tree here.
    assign tick = raw_tick & counter_clock_gate_enable_reg; // RL15

    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign do_read = S_AXI_ARVALID & arready_reg;
    assign stat_read = do_read && S_AXI_ARADDR == aoc_pkg::INT_STAT_OFS;
    assign expire = tick && periodic_timeout_value_reg != '0
        && pt_live_reg == '0 && !periodic_reload_bit_reg; // RL4 RL5

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign wr_ofs_data = merge(32'h0000_0000, wdata_reg, wstrb_reg);

    // Write address and data are captured independently, in either order.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end else if (S_AXI_AWVALID && awready_reg) begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            awaddr_reg <= S_AXI_AWADDR;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end else begin
            awready_reg <= ~aw_held_reg & ~bvalid_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (S_AXI_WVALID && wready_reg) begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end else begin
            wready_reg <= ~w_held_reg & ~bvalid_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= aoc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            if (awaddr_reg[1:0] != 2'h0
                || awaddr_reg > aoc_pkg::LP_CLK_CTL_OFS) begin
                bresp_reg <= aoc_pkg::RESP_SLVERR;
            end else begin
                bresp_reg <= aoc_pkg::RESP_OKAY;
            end
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Software-written configuration.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            free_counter_enable_reg <= 1'b0;
            periodic_timeout_value_reg <= aoc_pkg::CNT_RESET;
            int_mask_reg <= 1'b0;
            counter_clock_gate_enable_reg <= aoc_pkg::GATE_EN_RESET;
        end else if (do_write) begin
            if (awaddr_reg == aoc_pkg::FREE_CFG_OFS && wstrb_reg[0]) begin
                free_counter_enable_reg <= wdata_reg[aoc_pkg::FREE_EN_BIT];
            end else if (awaddr_reg == aoc_pkg::PT_CFG_OFS) begin
                periodic_timeout_value_reg <= merge(periodic_timeout_value_reg,
                                                    wdata_reg, wstrb_reg);
            end else if (awaddr_reg == aoc_pkg::INT_MASK_OFS
                         && wstrb_reg[0]) begin
                int_mask_reg <= wdata_reg[aoc_pkg::ALARM_BIT];
            end else if (awaddr_reg == aoc_pkg::LP_CLK_CTL_OFS
                         && wstrb_reg[0]) begin
                counter_clock_gate_enable_reg <= wdata_reg[aoc_pkg::GATE_EN_BIT];
            end
        end
    end

    // Requests wait for the next gated tick, a synchronised slow edge while the gate bit is set, which is the
    // acknowledgement; a stopped slow clock or a zero gate bit leaves them pending.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            alarm_clear_bit_reg <= 1'b0;
            periodic_reload_bit_reg <= 1'b0;
        end else begin
            if (do_write && awaddr_reg == aoc_pkg::PT_CTRL_OFS
                && wr_ofs_data[aoc_pkg::CLR_BIT]) begin
                alarm_clear_bit_reg <= 1'b1;
            end else if (tick) begin
                alarm_clear_bit_reg <= 1'b0; // RL7 RL14 RL16
            end
            if (do_write && awaddr_reg == aoc_pkg::PT_CTRL_OFS
                && wr_ofs_data[aoc_pkg::RELOAD_BIT]) begin
                periodic_reload_bit_reg <= 1'b1;
            end else if (tick) begin
                periodic_reload_bit_reg <= 1'b0; // RL7 RL14 RL16
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            free_cnt_reg <= aoc_pkg::CNT_RESET;
        end else if (tick && free_counter_enable_reg) begin
            free_cnt_reg <= free_cnt_reg + 1'b1; // RL1 RL2 RL17
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pt_live_reg <= aoc_pkg::CNT_RESET;
            periodic_count_value_reg <= aoc_pkg::CNT_RESET;
        end else if (tick) begin
            periodic_count_value_reg <= pt_live_reg; // RL10
            if (periodic_reload_bit_reg) begin
                pt_live_reg <= periodic_timeout_value_reg; // RL8
            end else if (periodic_timeout_value_reg == '0) begin
                pt_live_reg <= pt_live_reg; // RL5
            end else if (pt_live_reg == '0) begin
                pt_live_reg <= periodic_timeout_value_reg; // RL4
            end else begin
                pt_live_reg <= pt_live_reg - 1'b1; // RL3
            end
        end
    end

    // An expiry in the same slow cycle as a clear keeps the alarm set.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            alarm_reg <= 1'b0;
        end else if (expire) begin
            alarm_reg <= 1'b1; // RL6
        end else if (tick && alarm_clear_bit_reg) begin
            alarm_reg <= 1'b0; // RL9
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            int_stat_reg <= 1'b0;
        end else if (expire) begin
            int_stat_reg <= 1'b1;
        end else if (stat_read) begin
            int_stat_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (int_stat_reg | expire) & int_mask_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= aoc_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (do_read) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= aoc_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            if (S_AXI_ARADDR == aoc_pkg::FREE_CFG_OFS) begin
                rdata_reg[aoc_pkg::FREE_EN_BIT] <= free_counter_enable_reg;
            end else if (S_AXI_ARADDR == aoc_pkg::FREE_CNT_OFS) begin
                rdata_reg <= free_cnt_reg;
            end else if (S_AXI_ARADDR == aoc_pkg::PT_CTRL_OFS) begin
                rdata_reg[aoc_pkg::CLR_BIT] <= alarm_clear_bit_reg;
                rdata_reg[aoc_pkg::RELOAD_BIT] <= periodic_reload_bit_reg;
            end else if (S_AXI_ARADDR == aoc_pkg::PT_CFG_OFS) begin
                rdata_reg <= periodic_timeout_value_reg;
            end else if (S_AXI_ARADDR == aoc_pkg::PT_CNT_OFS) begin
                rdata_reg <= periodic_count_value_reg;
            end else if (S_AXI_ARADDR == aoc_pkg::INT_STAT_OFS) begin
                rdata_reg[aoc_pkg::ALARM_BIT] <= int_stat_reg;
            end else if (S_AXI_ARADDR == aoc_pkg::INT_MASK_OFS) begin
                rdata_reg[aoc_pkg::ALARM_BIT] <= int_mask_reg;
            end else if (S_AXI_ARADDR == aoc_pkg::LP_CLK_CTL_OFS) begin
                rdata_reg[aoc_pkg::GATE_EN_BIT] <=
                    counter_clock_gate_enable_reg;
            end else begin
                rresp_reg <= aoc_pkg::RESP_SLVERR;
            end
        end else if (rvalid_reg) begin
            if (S_AXI_RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end else begin
            arready_reg <= 1'b1;
        end
    end

    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign ALARM = alarm_reg;
    assign IRQ = irq_reg;
endmodule
`default_nettype wire

// File: aoc_counters_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module aoc_counters_assertions (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic ALARM
);
    default clocking dcb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic [7:0] rd_a;
    logic clr_seen;
    logic [7:0] wa;
    logic wd0;
    logic have_f;
    logic [31:0] last_f;
    wire logic rd_done = S_AXI_RVALID && S_AXI_RREADY;
    // Only an answered write of the clear bit to the control word arms it.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rd_a <= 8'h00;
            clr_seen <= 1'b0;
            wa <= 8'h00;
            wd0 <= 1'b0;
            have_f <= 1'b0;
            last_f <= 32'h0000_0000;
        end else begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                rd_a <= S_AXI_ARADDR;
            end
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                wa <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                wd0 <= S_AXI_WDATA[aoc_pkg::CLR_BIT];
            end
            if (S_AXI_BVALID && wa == aoc_pkg::PT_CTRL_OFS && wd0) begin
                clr_seen <= 1'b1;
            end else if (!ALARM) begin
                clr_seen <= 1'b0;
            end
            if (rd_done && rd_a == aoc_pkg::FREE_CNT_OFS) begin
                have_f <= 1'b1;
                last_f <= S_AXI_RDATA;
            end
        end
    end
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        rd_done == 1'b0 && S_AXI_RVALID
            |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_wr_resp;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            |-> ##2 S_AXI_BVALID;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("no bvalid");
    property p_rd_resp;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("no rvalid");
    property p_slverr;
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h1C |=> S_AXI_RVALID
            && S_AXI_RRESP == aoc_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped read ok");
    property p_alarm_hold;
        $rose(ALARM) |-> ALARM [*8];
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("short");
    property p_alarm_fall;
        $fell(ALARM) |-> clr_seen;
    endproperty
    a_alarm_fall: assert property (p_alarm_fall) else $error("fell");
    property p_free_mono;
        rd_done && rd_a == aoc_pkg::FREE_CNT_OFS && have_f
            |-> S_AXI_RDATA >= last_f;
    endproperty
    a_free_mono: assert property (p_free_mono) else $error("dropped");
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(x, y) begin checks++; if ((x) !== (y)) begin bad_count++; \
    $display("unexpected %0t %h vs %h", $time, (x), (y)); end end
module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic rtc_clk = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, alarm, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v, a, b, d;
    int bad_count = 0;
    int checks = 0;
    aoc_counters i_aoc_counters (.CLK(clk), .RESET_N(reset_n),
        .RTC_CLK(rtc_clk), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .ALARM(alarm), .IRQ(irq));
    initial begin
        forever #50 clk = ~clk;
    end
    // The slow clock runs free, as the always-on oscillator does.
    initial begin
        forever #15258.789 rtc_clk = ~rtc_clk;
    end
    task automatic end_sim();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic step(inout int n);
        @(posedge clk);
        n++;
        if (n > 100) begin
            bad_count++;
            $display("unexpected %0t timeout", $time);
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        int n = 0;
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid} <= {ad, dt, 2'b11};
        do begin
            step(n);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!((awready || !awvalid) && (wready || !wvalid)));
        bready <= 1'b1;
        do step(n); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
        int n = 0;
        @(posedge clk);
        {araddr, arvalid, rready} <= {ad, 2'b11};
        do step(n); while (!arready);
        arvalid <= 1'b0;
        do step(n); while (!rvalid);
        dt = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Reads sit a fixed offset after a slow edge, so tick counts are exact.
    task automatic rtc_wait(input int k);
        repeat (k) @(posedge rtc_clk);
        repeat (10) @(posedge clk);
    endtask
    task automatic span(input logic [7:0] ad, input int k);
        rtc_wait(1);
        rd(ad, a);
        rtc_wait(k);
        rd(ad, b);
        d = b - a;
    endtask
    task automatic poll(input int bt);
        int n = 0;
        do begin
            rd(aoc_pkg::PT_CTRL_OFS, v);
            n++;
            if (n > 200) step(n);
        end while (v[bt] !== 1'b0);
    endtask
    task automatic t_reset();
        rd(aoc_pkg::FREE_CFG_OFS, v);
        `CK(v, 32'h0000_0000)
        rd(aoc_pkg::PT_CFG_OFS, v);
        `CK(v, aoc_pkg::CNT_RESET)
        rd(aoc_pkg::LP_CLK_CTL_OFS, v);
        `CK(v[0], aoc_pkg::GATE_EN_RESET)
        rd(8'h20, v);
        `CK(r, aoc_pkg::RESP_SLVERR)
        wr(8'h02, 32'h0000_0001);
        `CK(r, aoc_pkg::RESP_SLVERR)
        `CK({alarm, irq}, 2'b00)
    endtask
    task automatic t_free();
        wr(aoc_pkg::FREE_CFG_OFS, 32'h0000_0001);
        `CK(r, aoc_pkg::RESP_OKAY)
        span(aoc_pkg::FREE_CNT_OFS, 5);
        `CK(a != 32'h0, 1'b1)
        `CK(d, 32'h0000_0005)
        wr(aoc_pkg::FREE_CFG_OFS, 32'h0000_0000);
        span(aoc_pkg::FREE_CNT_OFS, 3);
        `CK(d, 32'h0000_0000)
        wr(aoc_pkg::FREE_CFG_OFS, 32'h0000_0001);
        wr(aoc_pkg::LP_CLK_CTL_OFS, 32'h0000_0000);
        span(aoc_pkg::FREE_CNT_OFS, 3);
        `CK(d, 32'h0000_0000)
        wr(aoc_pkg::LP_CLK_CTL_OFS, 32'h0000_0001);
        span(aoc_pkg::FREE_CNT_OFS, 2);
        `CK(d, 32'h0000_0002)
    endtask
    task automatic t_periodic();
        // Starting just after a tick keeps the request ahead of the next one.
        rtc_wait(1);
        wr(aoc_pkg::PT_CFG_OFS, 32'h0000_0003);
        wr(aoc_pkg::PT_CTRL_OFS, 32'h0000_0002);
        rd(aoc_pkg::PT_CTRL_OFS, v);
        `CK(v[aoc_pkg::RELOAD_BIT], 1'b1)
        poll(aoc_pkg::RELOAD_BIT);
        rtc_wait(1);
        rd(aoc_pkg::PT_CNT_OFS, a);
        `CK(a, 32'h0000_0003)
        for (int i = 0; i < 5; i++) begin
            rtc_wait(1);
            rd(aoc_pkg::PT_CNT_OFS, b);
            `CK(b, (a == 32'h0) ? 32'h0000_0003 : a - 32'h1)
            a = b;
        end
        // The mask bit resets to zero, so the expiry shows on the alarm only.
        `CK({alarm, irq}, 2'b10)
        rd(aoc_pkg::INT_STAT_OFS, v);
        `CK(v[aoc_pkg::ALARM_BIT], 1'b1)
        repeat (2) @(posedge clk);
        `CK({alarm, irq}, 2'b10)
        wr(aoc_pkg::INT_MASK_OFS, 32'h0000_0001);
        rtc_wait(4);
        `CK({alarm, irq}, 2'b11)
        rd(aoc_pkg::INT_STAT_OFS, v);
        `CK(v[aoc_pkg::ALARM_BIT], 1'b1)
        repeat (2) @(posedge clk);
        `CK({alarm, irq}, 2'b10)
    endtask
    task automatic t_service();
        rtc_wait(1);
        wr(aoc_pkg::PT_CFG_OFS, 32'h0000_0000);
        wr(aoc_pkg::PT_CTRL_OFS, 32'h0000_0001);
        `CK(alarm, 1'b1)
        poll(aoc_pkg::CLR_BIT);
        `CK(alarm, 1'b0)
        span(aoc_pkg::PT_CNT_OFS, 3);
        `CK({d, alarm}, 33'h0)
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_free();
        t_periodic();
        t_service();
        end_sim();
    end
endmodule
bind aoc_counters aoc_counters_assertions i_aoc_counters_assertions (
    .CLK(CLK), .RESET_N(RESET_N), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .ALARM(ALARM));
`default_nettype wire
